// ---- audio_clk_core.sv ----
// Link-domain core: phase accumulator, field correction and clock dividers
`timescale 1ns/100ps
module audio_clk_core (
  // Link clock and reset
  input  wire logic                    linkClk,
  input  wire logic                    linkRst,
  // Settings, already stable in this domain
  input  wire audio_clk_pkg::audio_cfg_t cfg,
  // Field reference pulse, one link cycle
  input  wire logic                    fieldPulse,
  // Clock outputs
  output audio_clk_pkg::audio_clk_out_t clkOut,
  // Cycles counted in the last field
  output logic [audio_clk_pkg::CPF_W-1:0] lastCount
);
  logic [audio_clk_pkg::ACC_W-1:0]   accQ;
  logic [audio_clk_pkg::ACC_W-1:0]   incQ;
  logic [audio_clk_pkg::CPF_W-1:0]   cntQ;
  logic                              mclkQ;
  logic                              mclkPrevQ;
  logic [audio_clk_pkg::RATIO_W-1:0] bitDivQ;
  logic [audio_clk_pkg::RATIO_W-1:0] chDivQ;
  logic                              sclkQ;
  logic                              sclkPrevQ;
  logic                              lrclkQ;
  logic                              mRise;
  logic                              mFall;
  logic                              sRise;
  logic                              sFall;
  logic                              bitEdge;
  logic                              chEdge;

  // Master clock from accumulator top bit
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      accQ  <= '0;
      mclkQ <= 1'b0;
    end else begin
      accQ  <= accQ + incQ;
      mclkQ <= accQ[audio_clk_pkg::ACC_W-1];
    end
  end

  // Increment: nominal when open, corrected once per field when locked
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      incQ <= '0;
    end else if (cfg.loopOpenSelect) begin
      incQ <= audio_clk_pkg::ACC_W'(cfg.nominalIncrement); // [R5]
    end else if (fieldPulse) begin
      if (cntQ < cfg.cyclesPerField)
        incQ <= incQ + 1'b1; // [R10]
      else if (cntQ > cfg.cyclesPerField)
        incQ <= incQ - 1'b1; // [R10]
    end else if (incQ == '0) begin
      incQ <= audio_clk_pkg::ACC_W'(cfg.nominalIncrement); // [R10]
    end
  end

  assign mRise = mclkQ & ~mclkPrevQ;
  assign mFall = ~mclkQ & mclkPrevQ;
  assign sRise = sclkQ & ~sclkPrevQ;
  assign sFall = ~sclkQ & sclkPrevQ;
  assign bitEdge = cfg.bitClockPhase ? mRise : mFall; // [R8]
  assign chEdge  = cfg.channelClockPhase ? sRise : sFall; // [R7]

  // Cycle count per field
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      cntQ      <= '0;
      lastCount <= '0;
    end else if (fieldPulse) begin
      lastCount <= cntQ;
      cntQ      <= audio_clk_pkg::CPF_W'(mRise);
    end else if (mRise) begin
      cntQ <= cntQ + 1'b1;
    end
  end

  // Bit clock and channel clock dividers; each toggles at half its ratio
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      mclkPrevQ <= 1'b0;
      sclkPrevQ <= 1'b0;
      bitDivQ   <= '0;
      chDivQ    <= '0;
      sclkQ     <= 1'b0;
      lrclkQ    <= 1'b0;
    end else begin
      mclkPrevQ <= mclkQ;
      sclkPrevQ <= sclkQ;
      if (bitEdge) begin
        if (bitDivQ + 1'b1 >= (cfg.bitClockRatio >> 1)) begin
          bitDivQ <= '0;
          sclkQ   <= ~sclkQ; // [R9]
        end else begin
          bitDivQ <= bitDivQ + 1'b1;
        end
      end
      if (chEdge) begin
        if (chDivQ + 1'b1 >= (cfg.channelClockRatio >> 1)) begin
          chDivQ <= '0;
          lrclkQ <= ~lrclkQ; // [R9]
        end else begin
          chDivQ <= chDivQ + 1'b1;
        end
      end
    end
  end

  assign clkOut.audioMasterClock   = mclkQ;
  assign clkOut.serialBitClock     = sclkQ;
  assign clkOut.channelSelectClock = lrclkQ;
endmodule : audio_clk_core

// ---- audio_clk_pkg.sv ----
// Package with register map, field layouts and carrier types of the field-locked audio clock generator
package audio_clk_pkg;

  // Register indices (byte offsets as printed; byte address is four times the index)
  localparam logic [7:0] IDX_CPF_LOW   = 8'h30;
  localparam logic [7:0] IDX_CPF_MID   = 8'h31;
  localparam logic [7:0] IDX_CPF_HIGH  = 8'h32;
  localparam logic [7:0] IDX_INC_LOW   = 8'h34;
  localparam logic [7:0] IDX_INC_MID   = 8'h35;
  localparam logic [7:0] IDX_INC_HIGH  = 8'h36;
  localparam logic [7:0] IDX_BIT_RATIO = 8'h38;
  localparam logic [7:0] IDX_CH_RATIO  = 8'h39;
  localparam logic [7:0] IDX_CONTROL   = 8'h3a;
  localparam logic [7:0] IDX_STATUS    = 8'h3c;

  // Avalon-MM word address width (byte address / 4)
  localparam int          ADDR_W       = 8;

  // Field widths
  localparam int          CPF_W        = 18;
  localparam int          INC_W        = 22;
  localparam int          RATIO_W      = 6;
  localparam int          ACC_W        = 24;

  // Field positions in the control byte and masks of the partly used bytes
  localparam int          CTL_LOOP_OPEN  = 3;
  localparam int          CTL_VREF_SRC   = 2;
  localparam int          CTL_CH_PHASE   = 1;
  localparam int          CTL_BIT_PHASE  = 0;
  localparam logic [7:0]  CTL_MASK       = 8'h0f;
  localparam logic [7:0]  HIGH_CPF_MASK  = 8'h03;
  localparam logic [7:0]  HIGH_INC_MASK  = 8'h3f;
  localparam logic [7:0]  RATIO_MASK     = 8'h3f;

  // Reset values (none documented; plain defaults)
  localparam logic [CPF_W-1:0]   CPF_RESET   = 18'h00000;
  localparam logic [INC_W-1:0]   INC_RESET   = 22'h000000;
  localparam logic [RATIO_W-1:0] RATIO_RESET = 6'h00;
  localparam logic [3:0]         CTL_RESET   = 4'h0;

  // Settings passed into the link domain
  typedef struct packed {
    logic [CPF_W-1:0]   cyclesPerField;
    logic [INC_W-1:0]   nominalIncrement;
    logic [RATIO_W-1:0] bitClockRatio;
    logic [RATIO_W-1:0] channelClockRatio;
    logic               loopOpenSelect;
    logic               verticalRefSource;
    logic               channelClockPhase;
    logic               bitClockPhase;
  } audio_cfg_t;

  // Audio clock outputs
  typedef struct packed {
    logic audioMasterClock;
    logic serialBitClock;
    logic channelSelectClock;
  } audio_clk_out_t;

endpackage : audio_clk_pkg

// ---- audio_clk_sva.sv ----
// Port checker of the field-locked audio clock generator
`timescale 1ns/100ps
module audio_clk_sva (
  // Clocks and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        linkClk,
  // Register bus
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // Audio clocks
  input wire logic        audio_master_clock,
  input wire logic        serial_bit_clock
);
  logic m1_q;
  logic m2_q;
  logic b1_q;
  // Previous clock levels
  always_ff @(posedge linkClk) begin
    m1_q <= audio_master_clock;
    m2_q <= m1_q;
    b1_q <= serial_bit_clock;
  end
  wait_reset_a: assert property (@(posedge ref_clk) rst |=> waitrequest)
    else $error("waitrequest low in reset");
  wait_pulse_a: assert property (@(posedge ref_clk) disable iff (rst) !waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  wait_cause_a: assert property (@(posedge ref_clk) disable iff (rst) !waitrequest |-> (read || write))
    else $error("answer without request");
  answer_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
    (read || write) && waitrequest |-> ##[1:2] !waitrequest)
    else $error("request not answered");
  rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(readdata) |-> (!waitrequest && read))
    else $error("readdata moved without read");
  clk_reset_a: assert property (@(posedge linkClk) rst [*5] |-> !audio_master_clock && !serial_bit_clock)
    else $error("clock active in reset");
  bit_div_a: assert property (@(posedge linkClk) disable iff (rst)
    (serial_bit_clock != b1_q) |-> (audio_master_clock != m1_q) || (m1_q != m2_q))
    else $error("bit clock moved without master edge");
  mclk_rate_a: assert property (@(posedge linkClk) disable iff (rst)
    (audio_master_clock != m1_q) |=> $stable(audio_master_clock))
    else $error("master clock too fast");
endmodule : audio_clk_sva
bind field_locked_audio_clock_gen audio_clk_sva i_audio_clk_sva (.ref_clk(ref_clk), .rst(rst),
  .linkClk(linkClk), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .audio_master_clock(audio_master_clock), .serial_bit_clock(serial_bit_clock));

// ---- audio_serial_rx.sv ----
// Audio serial receiver model watching the clock outputs
`timescale 1ns/100ps
module audio_serial_rx (
  // Link clock
  input wire logic  linkClk,
  // Audio clocks
  input wire logic  masterClk,
  input wire logic  bitClk,
  input wire logic  chanClk,
  // Observations
  input wire logic  clearSeen,
  output logic [7:0] masterPerBit,
  output logic [7:0] bitPerChan,
  output logic [1:0] masterAtBit,
  output logic [1:0] bitAtChan
);
  logic       m_q = 1'b0;
  logic       b_q = 1'b0;
  logic       c_q = 1'b0;
  logic [7:0] mCnt_q = 8'h00;
  logic [7:0] bCnt_q = 8'h00;
  always_ff @(posedge linkClk) begin
    m_q <= masterClk;
    b_q <= bitClk;
    c_q <= chanClk;
  end
  // Rises per divided period
  always_ff @(posedge linkClk) begin
    if (bitClk && !b_q) begin
      masterPerBit <= mCnt_q;
      mCnt_q <= {7'h00, masterClk && !m_q};
    end else
      mCnt_q <= mCnt_q + {7'h00, masterClk && !m_q};
    if (chanClk && !c_q) begin
      bitPerChan <= bCnt_q;
      bCnt_q <= {7'h00, bitClk && !b_q};
    end else
      bCnt_q <= bCnt_q + {7'h00, bitClk && !b_q};
  end
  // Source level seen at each launched edge
  always_ff @(posedge linkClk) begin
    if (clearSeen) begin
      masterAtBit <= 2'b00;
      bitAtChan <= 2'b00;
    end else begin
      if (bitClk != b_q) masterAtBit[masterClk] <= 1'b1;
      if (chanClk != c_q) bitAtChan[bitClk] <= 1'b1;
    end
  end
endmodule : audio_serial_rx

// ---- field_locked_audio_clock_gen.sv ----
// Top: Avalon-MM register file, clock crossings and field-locked audio clock generator
// What this block does
// R1 - An 18-bit master-clock cycles-per-field target is kept across bytes 30h, 31h and bits 1:0 of 32h.
// R2 - A 22-bit nominal increment is kept across bytes 34h, 35h and bits 5:0 of 36h.
// R3 - Bits 5:0 of byte 38h give the master-to-bit-clock ratio, upper bits unused.
// R4 - Bits 5:0 of byte 39h give the bit-to-channel-clock ratio, upper bits unused.
// R5 - Control bit 3 low locks the master clock to the field rate, high lets it run free.
// R6 - Control bit 2 low takes the field reference from the decoder, high from the expansion input.
// R7 - Control bit 1 picks falling (0) or rising (1) bit-clock edges to launch channel clock edges.
// R8 - Control bit 0 picks falling (0) or rising (1) master-clock edges to launch bit clock edges.
// R9 - The bit clock divides the master clock by its ratio and the channel clock divides the bit clock by its ratio.
// The code counts ratio/2 edges rounded down: odd ratios from 3 divide by one less, 0 and 1 by two.
// R10 - When locked, an accumulator advances by the increment and is corrected each field to hit the target count.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/100ps
module field_locked_audio_clock_gen (
  // System clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  // Avalon-MM slave
  input  wire logic [audio_clk_pkg::ADDR_W-1:0] address,
  input  wire logic                            read,
  input  wire logic                            write,
  input  wire logic [31:0]                     writedata,
  input  wire logic [3:0]                      byteenable,
  output logic      [31:0]                     readdata,
  output logic                                 waitrequest,
  // Link clock domain
  input  wire logic                            linkClk,
  input  wire logic                            decoderVertRef,
  input  wire logic                            expansion_vertical_ref_in,
  // Audio clock outputs
  output logic                                 audio_master_clock,
  output logic                                 serial_bit_clock,
  output logic                                 channel_select_clock
);
  // Registers in the system domain
  logic [audio_clk_pkg::CPF_W-1:0]   cpfQ;
  logic [audio_clk_pkg::INC_W-1:0]   incQ;
  logic [audio_clk_pkg::RATIO_W-1:0] bitRatioQ;
  logic [audio_clk_pkg::RATIO_W-1:0] chRatioQ;
  logic [3:0]                        ctlQ;
  logic                              accessDoneQ;
  logic                              wrEn;
  logic                              rdEn;
  logic [31:0]                       rdData;
  audio_clk_pkg::audio_cfg_t         cfgSys;

  // Configuration crossing (handshake)
  audio_clk_pkg::audio_cfg_t         cfgHoldQ;
  logic                              reqQ;
  logic                              ackSync1Q;
  logic                              ackSync2Q;
  logic                              reqSync1Q;
  logic                              reqSync2Q;
  logic                              reqSync3Q;
  logic                              ackLinkQ;
  audio_clk_pkg::audio_cfg_t         cfgLinkQ;

  // Link reset and reference sampling
  logic                              linkRstSync1Q;
  logic                              linkRstQ;
  logic                              decSync1Q;
  logic                              decSync2Q;
  logic                              expSync1Q;
  logic                              expSync2Q;
  logic                              vrefPrevQ;
  logic                              vrefSel;
  logic                              fieldPulse;

  // Status back to system domain
  logic [audio_clk_pkg::CPF_W-1:0]   lastCount;
  logic [audio_clk_pkg::CPF_W-1:0]   cntHoldQ;
  logic                              stReqQ;
  logic                              stAckSync1Q;
  logic                              stAckSync2Q;
  logic                              stReqSync1Q;
  logic                              stReqSync2Q;
  logic                              stReqSync3Q;
  logic [audio_clk_pkg::CPF_W-1:0]   statusQ;

  audio_clk_pkg::audio_clk_out_t     clkOut;

  // Bus slave: one wait cycle, answer on the second edge
  assign wrEn = write & accessDoneQ;
  assign rdEn = read & ~accessDoneQ;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      accessDoneQ <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else begin
      accessDoneQ <= (read | write) & ~accessDoneQ;
      waitrequest <= ~((read | write) & ~accessDoneQ);
      if (rdEn)
        readdata <= rdData;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpfQ      <= audio_clk_pkg::CPF_RESET;
      incQ      <= audio_clk_pkg::INC_RESET;
      bitRatioQ <= audio_clk_pkg::RATIO_RESET;
      chRatioQ  <= audio_clk_pkg::RATIO_RESET;
      ctlQ      <= audio_clk_pkg::CTL_RESET;
    end else if (wrEn && byteenable[0]) begin
      case (address)
        audio_clk_pkg::IDX_CPF_LOW:   cpfQ[7:0]   <= writedata[7:0]; // [R1]
        audio_clk_pkg::IDX_CPF_MID:   cpfQ[15:8]  <= writedata[7:0]; // [R1]
        audio_clk_pkg::IDX_CPF_HIGH:  cpfQ[17:16] <= writedata[1:0]; // [R1]
        audio_clk_pkg::IDX_INC_LOW:   incQ[7:0]   <= writedata[7:0]; // [R2]
        audio_clk_pkg::IDX_INC_MID:   incQ[15:8]  <= writedata[7:0]; // [R2]
        audio_clk_pkg::IDX_INC_HIGH:  incQ[21:16] <= writedata[5:0]; // [R2]
        audio_clk_pkg::IDX_BIT_RATIO: bitRatioQ   <= writedata[5:0]; // [R3]
        audio_clk_pkg::IDX_CH_RATIO:  chRatioQ    <= writedata[5:0]; // [R4]
        audio_clk_pkg::IDX_CONTROL:   ctlQ        <= writedata[3:0];
        default: ;
      endcase
    end
  end

  // Read mux; unused bits and unmapped addresses read zero
  always_comb begin
    rdData = '0;
    case (address)
      audio_clk_pkg::IDX_CPF_LOW:   rdData[7:0] = cpfQ[7:0];
      audio_clk_pkg::IDX_CPF_MID:   rdData[7:0] = cpfQ[15:8];
      audio_clk_pkg::IDX_CPF_HIGH:  rdData[1:0] = cpfQ[17:16];
      audio_clk_pkg::IDX_INC_LOW:   rdData[7:0] = incQ[7:0];
      audio_clk_pkg::IDX_INC_MID:   rdData[7:0] = incQ[15:8];
      audio_clk_pkg::IDX_INC_HIGH:  rdData[5:0] = incQ[21:16];
      audio_clk_pkg::IDX_BIT_RATIO: rdData[5:0] = bitRatioQ;
      audio_clk_pkg::IDX_CH_RATIO:  rdData[5:0] = chRatioQ;
      audio_clk_pkg::IDX_CONTROL:   rdData[3:0] = ctlQ;
      audio_clk_pkg::IDX_STATUS:    rdData[audio_clk_pkg::CPF_W-1:0] = statusQ;
      default:                      rdData = '0;
    endcase
  end

  always_comb begin
    cfgSys.cyclesPerField    = cpfQ;
    cfgSys.nominalIncrement  = incQ;
    cfgSys.bitClockRatio     = bitRatioQ;
    cfgSys.channelClockRatio = chRatioQ;
    cfgSys.loopOpenSelect    = ctlQ[audio_clk_pkg::CTL_LOOP_OPEN];
    cfgSys.verticalRefSource = ctlQ[audio_clk_pkg::CTL_VREF_SRC];
    cfgSys.channelClockPhase = ctlQ[audio_clk_pkg::CTL_CH_PHASE];
    cfgSys.bitClockPhase     = ctlQ[audio_clk_pkg::CTL_BIT_PHASE];
  end

  // Config handshake, system side: capture and toggle when idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ackSync1Q <= 1'b0;
      ackSync2Q <= 1'b0;
    end else begin
      ackSync1Q <= ackLinkQ;
      ackSync2Q <= ackSync1Q;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reqQ     <= 1'b0;
      cfgHoldQ <= '0;
    end else if (reqQ == ackSync2Q) begin
      cfgHoldQ <= cfgSys;
      reqQ     <= ~reqQ;
    end
  end

  // Link reset synchroniser
  always_ff @(posedge linkClk) begin
    linkRstSync1Q <= rst;
    linkRstQ      <= linkRstSync1Q;
  end

  // Config handshake, link side
  always_ff @(posedge linkClk) begin
    if (linkRstQ) begin
      reqSync1Q <= 1'b0;
      reqSync2Q <= 1'b0;
      reqSync3Q <= 1'b0;
      ackLinkQ  <= 1'b0;
      cfgLinkQ  <= '0;
    end else begin
      reqSync1Q <= reqQ;
      reqSync2Q <= reqSync1Q;
      reqSync3Q <= reqSync2Q;
      if (reqSync2Q != reqSync3Q) begin
        cfgLinkQ <= cfgHoldQ;
        ackLinkQ <= reqSync2Q;
      end
    end
  end

  // Field reference inputs and source selection
  always_ff @(posedge linkClk) begin
    if (linkRstQ) begin
      decSync1Q <= 1'b0;
      decSync2Q <= 1'b0;
      expSync1Q <= 1'b0;
      expSync2Q <= 1'b0;
      vrefPrevQ <= 1'b0;
    end else begin
      decSync1Q <= decoderVertRef;
      decSync2Q <= decSync1Q;
      expSync1Q <= expansion_vertical_ref_in;
      expSync2Q <= expSync1Q;
      vrefPrevQ <= vrefSel;
    end
  end

  assign vrefSel    = cfgLinkQ.verticalRefSource ? expSync2Q : decSync2Q; // [R6]
  assign fieldPulse = vrefSel & ~vrefPrevQ;

  audio_clk_core u_core (
    .linkClk    (linkClk),
    .linkRst    (linkRstQ),
    .cfg        (cfgLinkQ),
    .fieldPulse (fieldPulse),
    .clkOut     (clkOut),
    .lastCount  (lastCount)
  );

  // Output registers
  always_ff @(posedge linkClk) begin
    if (linkRstQ) begin
      audio_master_clock   <= 1'b0;
      serial_bit_clock     <= 1'b0;
      channel_select_clock <= 1'b0;
    end else begin
      audio_master_clock   <= clkOut.audioMasterClock;
      serial_bit_clock     <= clkOut.serialBitClock;
      channel_select_clock <= clkOut.channelSelectClock;
    end
  end

  // Status handshake: last field count to system domain
  always_ff @(posedge linkClk) begin
    if (linkRstQ) begin
      stAckSync1Q <= 1'b0;
      stAckSync2Q <= 1'b0;
      stReqQ      <= 1'b0;
      cntHoldQ    <= '0;
    end else begin
      stAckSync1Q <= stReqSync3Q;
      stAckSync2Q <= stAckSync1Q;
      if (stReqQ == stAckSync2Q) begin
        cntHoldQ <= lastCount;
        stReqQ   <= ~stReqQ;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stReqSync1Q <= 1'b0;
      stReqSync2Q <= 1'b0;
      stReqSync3Q <= 1'b0;
      statusQ     <= '0;
    end else begin
      stReqSync1Q <= stReqQ;
      stReqSync2Q <= stReqSync1Q;
      stReqSync3Q <= stReqSync2Q;
      if (stReqSync2Q != stReqSync3Q)
        statusQ <= cntHoldQ;
    end
  end
endmodule : field_locked_audio_clock_gen

// ---- field_locked_audio_clock_gen_tb_top.sv ----
// Testbench of the field-locked audio clock generator
`timescale 1ns/100ps
module field_locked_audio_clock_gen_tb_top;
  logic        ref_clk, rst, linkClk, read, write, waitrequest, clearSeen;
  logic [7:0]  address, masterPerBit, bitPerChan;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  logic        decoderVertRef, expansion_vertical_ref_in;
  logic        audio_master_clock, serial_bit_clock, channel_select_clock;
  logic [1:0]  masterAtBit, bitAtChan;
  int          mismatches, compares, decPer, expPer, decCnt, expCnt;
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3.7;
    forever #6 linkClk = ~linkClk;
  end
  // Field references from decoder and expansion port
  always @(posedge linkClk) begin
    decCnt <= (decCnt >= decPer - 1) ? 0 : decCnt + 1;
    expCnt <= (expCnt >= expPer - 1) ? 0 : expCnt + 1;
    decoderVertRef <= (decCnt < 4);
    expansion_vertical_ref_in <= (expCnt < 4);
  end
  field_locked_audio_clock_gen i_field_locked_audio_clock_gen (.ref_clk(ref_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .linkClk(linkClk), .decoderVertRef(decoderVertRef),
    .expansion_vertical_ref_in(expansion_vertical_ref_in), .audio_master_clock(audio_master_clock),
    .serial_bit_clock(serial_bit_clock), .channel_select_clock(channel_select_clock));
  audio_serial_rx i_audio_serial_rx (.linkClk(linkClk), .masterClk(audio_master_clock),
    .bitClk(serial_bit_clock), .chanClk(channel_select_clock), .clearSeen(clearSeen),
    .masterPerBit(masterPerBit), .bitPerChan(bitPerChan), .masterAtBit(masterAtBit), .bitAtChan(bitAtChan));
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_value
  task automatic check_flag(input logic got);
    check_value({31'h0, got}, 32'h1);
  endtask : check_flag
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus_op(input logic wr, input logic [3:0] be, input logic [7:0] idx,
                        input logic [7:0] data, output logic [31:0] rdata);
    @(posedge ref_clk);
    address <= idx;
    writedata <= {24'h000000, data};
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus_op
  task automatic setup(input logic [21:0] inc, input logic [17:0] cpf, input logic [7:0] br, cr, ctl);
    logic [31:0] rd;
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_CPF_LOW, cpf[7:0], rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_CPF_MID, cpf[15:8], rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_CPF_HIGH, {6'h00, cpf[17:16]}, rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_INC_LOW, inc[7:0], rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_INC_MID, inc[15:8], rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_INC_HIGH, {2'h0, inc[21:16]}, rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_BIT_RATIO, br, rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_CH_RATIO, cr, rd);
    bus_op(1'b1, 4'h1, audio_clk_pkg::IDX_CONTROL, ctl, rd);
    repeat (50) @(posedge linkClk);
  endtask : setup
  task automatic regs_task;
    logic [7:0]  idx [9];
    logic [7:0]  msk [9];
    logic [31:0] rd;
    idx = '{8'h30, 8'h31, 8'h32, 8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3a};
    msk = '{8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'h3f, 8'h3f, 8'h3f, 8'h0f};
    foreach (idx[i]) begin
      bus_op(1'b1, 4'h1, idx[i], 8'hff, rd);
      bus_op(1'b1, 4'h0, idx[i], 8'h00, rd);
      bus_op(1'b0, 4'h1, idx[i], 8'h00, rd);
      check_value({24'h0, rd[7:0]}, {24'h0, msk[i]});
      bus_op(1'b1, 4'h1, idx[i], 8'h5a, rd);
      bus_op(1'b0, 4'h1, idx[i], 8'h00, rd);
      check_value({24'h0, rd[7:0]}, {24'h0, 8'h5a & msk[i]});
    end
    bus_op(1'b0, 4'h1, 8'h33, 8'h00, rd);
    check_value(rd, 32'h0);
  endtask : regs_task
  task automatic ratio_task;
    setup(22'h200000, 18'd50, 8'h04, 8'h06, 8'h08);
    repeat (800) @(posedge linkClk);
    check_value({24'h0, masterPerBit}, 32'd4);
    check_value({24'h0, bitPerChan}, 32'd6);
  endtask : ratio_task
  task automatic phase_task;
    for (int i = 0; i < 4; i++) begin
      setup(22'h200000, 18'd50, 8'h02, 8'h02, {6'h02, i[1:0]});
      clearSeen <= 1'b1;
      @(posedge linkClk);
      clearSeen <= 1'b0;
      repeat (600) @(posedge linkClk);
      check_value({30'h0, masterAtBit}, i[0] ? 32'h2 : 32'h1);
      check_value({30'h0, bitAtChan}, i[1] ? 32'h2 : 32'h1);
    end
  endtask : phase_task
  // Counted master cycles per field against field length times rate
  task automatic field_task;
    logic [7:0]  ctl [3];
    logic [31:0] rd;
    int          e;
    ctl = '{8'h08, 8'h0c, 8'h00};
    for (int j = 0; j < 3; j++) begin
      setup(22'h200000, (j == 2) ? 18'd50 : 18'd200, 8'h04, 8'h04, ctl[j]);
      repeat (2000) @(posedge linkClk);
      e = ((j == 1) ? expPer : decPer) * 8 / 64;
      bus_op(1'b0, 4'h1, audio_clk_pkg::IDX_STATUS, 8'h00, rd);
      check_flag(rd[17:0] >= e - 1 && rd[17:0] <= e + 1);
    end
  endtask : field_task
  initial begin
    #2000000;
    mismatches++;
    report_and_stop;
  end
  initial begin
    {rst, read, write, clearSeen} = 4'h8;
    {address, writedata, byteenable} = '0;
    {decoderVertRef, expansion_vertical_ref_in} = 2'h0;
    {decPer, expPer, decCnt, expCnt, mismatches, compares} = {32'd400, 32'd800, 128'h0};
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    regs_task;
    ratio_task;
    phase_task;
    field_task;
    report_and_stop;
  end
endmodule : field_locked_audio_clock_gen_tb_top
